// File: include/trc_map.vh
// Constants for the transfer remote control block
// Operation
// RL1 - Remote inputs act only when remote selected
// RL2 - Remote pulses held at least 250 ms
// RL3 - RF enable input turns on-air Rf_enable_input
// RL4 - RF disable input turns on-air Rf_disable_input
// RL5 - Disable or auto RF ends maintenance mode
// RL6 - First-to-air selects first, manual, no maintenance
// RL7 - Second-to-air selects second, manual, no maintenance
// RL8 - Auto RF input sets automatic RF transfer
// RL9 - Auto RF entry routes main to antenna
// RL10 - Auto audio input sets automatic audio transfer
// RL11 - Held auto audio blocks panel, link audio
// RL12 - Main audio input selects main, manual audio
// RL13 - Backup audio input selects backup, manual audio
// RL14 - Dummy-load RF needs interlock low, always
// RL15 - Two position drives, one per position
// RL16 - Indication contacts report reached switch position
// RL17 - Switch interlock opens before moving contacts
// RL18 - Open interlock or mismatch inhibits all RF
// RL19 - Inputs synchronised, debounced, act on assertion
// RL20 - Conflicting RF group inputs do nothing
// RL21 - Conflicting audio group inputs do nothing
// RL22 - RF enable plus disable obeys disable
// RL23 - Remote command beats conflicting local command
`ifndef TRC_MAP_VH
`define TRC_MAP_VH

// ==================================================
// Timing
`define TRC_CLK_KHZ 40000
`define TRC_DEBOUNCE_MS 5
`define TRC_DEBOUNCE_CYC 18'h30d40
`define TRC_CNT_W 18

// ==================================================
// Register offsets
`define TRC_ADDR_W 4
`define TRC_DATA_W 16
`define TRC_REG_CMD 4'h0
`define TRC_REG_CFG 4'h4
`define TRC_REG_STAT 4'h8
`define TRC_REG_INPUT 4'hc

// ==================================================
// Command register bits (write one to act)
`define TRC_CMD_RF_ENABLE_INPUT 0
`define TRC_CMD_RF_DISABLE_INPUT 1
`define TRC_CMD_FIRST 2
`define TRC_CMD_SECOND 3
`define TRC_CMD_AUTO_RF 4
`define TRC_CMD_AES_MAIN 5
`define TRC_CMD_AES_BACKUP 6
`define TRC_CMD_AES_AUTO 7
`define TRC_CMD_MAINT_ON 8
`define TRC_CMD_LINK_MAIN 9
`define TRC_CMD_LINK_BACKUP 10
`define TRC_CMD_LINK_AUTO 11

// ==================================================
// Configuration bits and reset value
`define TRC_CFG_REMOTE 0
`define TRC_CFG_RESET 1'h0

// ==================================================
// Input vector positions
`define TRC_NIN 12
`define TRC_IN_RF_ENABLE_INPUT 0
`define TRC_IN_RF_DISABLE_INPUT 1
`define TRC_IN_FIRST 2
`define TRC_IN_SECOND 3
`define TRC_IN_AUTO_RF 4
`define TRC_IN_AUTO_AES 5
`define TRC_IN_MAIN_AES 6
`define TRC_IN_BACKUP_AES 7
`define TRC_IN_DUMMY_OK 8
`define TRC_IN_IND_FIRST 9
`define TRC_IN_IND_SECOND 10
`define TRC_IN_LOOP_CLOSED 11

`endif

// File: verilog/trc_top.v
// Transfer controller: remote inputs, modes, coax switch and RF gating
//
// Design decisions made here: the address map and the strobed register port.
`include "trc_map.vh"

module trc_top #(
    parameter [`TRC_CNT_W-1:0] DEBOUNCE_CYC = `TRC_DEBOUNCE_CYC
)(
    // Clock, reset, enable
    input wire clk_sys,
    input wire rst,
    input wire ce,
    // Register port
    input wire [`TRC_ADDR_W-1:0] reg_addr,
    input wire [`TRC_DATA_W-1:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [`TRC_DATA_W-1:0] reg_rdata,
    // Remote control pins, active low
    input wire rf_enable_input_n,
    input wire rf_disable_input_n,
    input wire first_xmtr_to_antenna_n,
    input wire second_xmtr_to_antenna_n,
    input wire auto_rf_transfer_input_n,
    input wire auto_aes_transfer_input_n,
    input wire main_aes_select_input_n,
    input wire backup_aes_select_input_n,
    input wire dummy_load_interlock_n,
    // Coaxial switch contacts, active low
    input wire switch_ind_first_n,
    input wire switch_ind_second_n,
    input wire switch_loop_closed_n,
    // Coaxial switch position drives
    output reg switch_drive_first,
    output reg switch_drive_second,
    // Transmitter RF enables
    output reg rf_enable_first_transmitter,
    output reg rf_enable_second_transmitter,
    // Indicators
    output reg led_rf_enable_input,
    output reg led_first_select,
    output reg led_second_select,
    output reg led_rf_auto,
    output reg led_aes_auto,
    output reg led_aes_main,
    output reg led_aes_backup,
    output reg led_maintenance,
    output reg aes_source_backup
);

    // ==================================================
    // Helpers
    // True when a is the only one of three asserted
    function sole3;
        input a, b, c;
        begin
            sole3 = a & ~b & ~c;
        end
    endfunction

    localparam SW_READY = 2'b01;
    localparam SW_MOVE = 2'b10;

    // ==================================================
    // Input synchronising and debouncing
    wire [`TRC_NIN-1:0] pin_n;
    assign pin_n = {switch_loop_closed_n, switch_ind_second_n,
                    switch_ind_first_n, dummy_load_interlock_n,
                    backup_aes_select_input_n, main_aes_select_input_n,
                    auto_aes_transfer_input_n, auto_rf_transfer_input_n,
                    second_xmtr_to_antenna_n, first_xmtr_to_antenna_n,
                    rf_disable_input_n, rf_enable_input_n};

    reg [`TRC_NIN-1:0] lvl, lvl_d;
    wire [`TRC_NIN-1:0] act;
    genvar gi;
    generate
        for (gi = 0; gi < `TRC_NIN; gi = gi + 1)
        begin : g_in
            reg s1, s2, s3;
            reg [`TRC_CNT_W-1:0] cnt;
            // Stage one feeds stage two only; idle pins read high
            always @(posedge clk_sys)
            begin
                if (rst)
                begin
                    s1 <= 1'h1;
                    s2 <= 1'h1;
                    s3 <= 1'h1;
                    cnt <= {`TRC_CNT_W{1'b0}};
                    lvl[gi] <= 1'h0;
                    lvl_d[gi] <= 1'h0;
                end
                else if (ce)
                begin
                    s1 <= pin_n[gi];
                    s2 <= s1;
                    s3 <= s2;
                    lvl_d[gi] <= lvl[gi];
                    // Level must hold a full debounce time to count
                    if (s2 != s3 || (~s3) == lvl[gi]) // RL19
                        cnt <= {`TRC_CNT_W{1'b0}};
                    else if (cnt >= DEBOUNCE_CYC - 1'b1)
                    begin
                        lvl[gi] <= ~s3;
                        cnt <= {`TRC_CNT_W{1'b0}};
                    end
                    else
                        cnt <= cnt + 1'b1;
                end
            end
            assign act[gi] = lvl[gi] & ~lvl_d[gi]; // RL19
        end
    endgenerate

    // ==================================================
    // Control state
    reg cfg_remote, rf_enable_input, main_sel, rf_auto, aes_auto;
    reg aes_backup, maint, pos_cmd;
    reg [1:0] sw_state;
    wire rem, rf_grp_ok, aes_grp_ok, r_on, r_off, r_first, r_second;
    wire r_auto, r_aes_auto, r_aes_main, r_aes_backup, aes_lock, cmd_wr;

    assign rem = cfg_remote; // RL1
    assign r_off = rem & (act[`TRC_IN_RF_DISABLE_INPUT]
        | (act[`TRC_IN_RF_ENABLE_INPUT] & lvl[`TRC_IN_RF_DISABLE_INPUT])); // RL22
    assign r_on = rem & act[`TRC_IN_RF_ENABLE_INPUT] & ~lvl[`TRC_IN_RF_DISABLE_INPUT];
    assign rf_grp_ok = sole3(lvl[`TRC_IN_FIRST], lvl[`TRC_IN_SECOND],
                              lvl[`TRC_IN_AUTO_RF])
        | sole3(lvl[`TRC_IN_SECOND], lvl[`TRC_IN_FIRST],
                lvl[`TRC_IN_AUTO_RF])
        | sole3(lvl[`TRC_IN_AUTO_RF], lvl[`TRC_IN_FIRST],
                lvl[`TRC_IN_SECOND]); // RL20
    assign aes_grp_ok = sole3(lvl[`TRC_IN_AUTO_AES], lvl[`TRC_IN_MAIN_AES],
                              lvl[`TRC_IN_BACKUP_AES])
        | sole3(lvl[`TRC_IN_MAIN_AES], lvl[`TRC_IN_AUTO_AES],
                lvl[`TRC_IN_BACKUP_AES])
        | sole3(lvl[`TRC_IN_BACKUP_AES], lvl[`TRC_IN_AUTO_AES],
                lvl[`TRC_IN_MAIN_AES]); // RL21
    assign r_first = rem & rf_grp_ok & act[`TRC_IN_FIRST];
    assign r_second = rem & rf_grp_ok & act[`TRC_IN_SECOND];
    assign r_auto = rem & rf_grp_ok & act[`TRC_IN_AUTO_RF];
    assign r_aes_auto = rem & aes_grp_ok & act[`TRC_IN_AUTO_AES];
    assign r_aes_main = rem & aes_grp_ok & act[`TRC_IN_MAIN_AES];
    assign r_aes_backup = rem & aes_grp_ok & act[`TRC_IN_BACKUP_AES];
    assign aes_lock = rem & lvl[`TRC_IN_AUTO_AES]; // RL11
    assign cmd_wr = reg_wr && reg_addr == `TRC_REG_CMD;

    // Local actions first, remote ones after so they win the same cycle
    always @(posedge clk_sys)
    begin
        if (rst)
        begin
            cfg_remote <= `TRC_CFG_RESET;
            {rf_enable_input, main_sel, rf_auto, aes_auto} <= 4'h0;
            {aes_backup, maint, pos_cmd} <= 3'h0;
        end
        else if (ce)
        begin
            if (reg_wr && reg_addr == `TRC_REG_CFG)
                cfg_remote <= reg_wdata[`TRC_CFG_REMOTE];
            if (cmd_wr)
            begin
                if (reg_wdata[`TRC_CMD_RF_DISABLE_INPUT])
                    rf_enable_input <= 1'h0;
                else if (reg_wdata[`TRC_CMD_RF_ENABLE_INPUT])
                    rf_enable_input <= 1'h1;
                if (reg_wdata[`TRC_CMD_MAINT_ON])
                    maint <= 1'h1;
                if (reg_wdata[`TRC_CMD_FIRST])
                begin
                    main_sel <= 1'h0;
                    pos_cmd <= 1'h0;
                    rf_auto <= 1'h0;
                    maint <= 1'h0;
                end
                else if (reg_wdata[`TRC_CMD_SECOND])
                begin
                    main_sel <= 1'h1;
                    pos_cmd <= 1'h1;
                    rf_auto <= 1'h0;
                    maint <= 1'h0;
                end
                else if (reg_wdata[`TRC_CMD_AUTO_RF])
                begin
                    rf_auto <= 1'h1;
                    pos_cmd <= main_sel;
                    maint <= 1'h0;
                end
                // Panel and link audio lose while auto audio pin is held in remote mode
                if (!aes_lock) // RL11
                begin
                    if (reg_wdata[`TRC_CMD_AES_AUTO]
                        | reg_wdata[`TRC_CMD_LINK_AUTO])
                        aes_auto <= 1'h1;
                    else if (reg_wdata[`TRC_CMD_AES_MAIN]
                        | reg_wdata[`TRC_CMD_LINK_MAIN])
                    begin
                        aes_backup <= 1'h0;
                        aes_auto <= 1'h0;
                    end
                    else if (reg_wdata[`TRC_CMD_AES_BACKUP]
                        | reg_wdata[`TRC_CMD_LINK_BACKUP])
                    begin
                        aes_backup <= 1'h1;
                        aes_auto <= 1'h0;
                    end
                end
            end
            // Remote commands, assigned last so they win
            if (r_off) // RL23
            begin
                rf_enable_input <= 1'h0; // RL4
                maint <= 1'h0; // RL5
            end
            else if (r_on)
                rf_enable_input <= 1'h1; // RL3
            if (r_first)
            begin
                main_sel <= 1'h0; // RL6
                pos_cmd <= 1'h0;
                rf_auto <= 1'h0;
                maint <= 1'h0;
            end
            if (r_second)
            begin
                main_sel <= 1'h1; // RL7
                pos_cmd <= 1'h1;
                rf_auto <= 1'h0;
                maint <= 1'h0;
            end
            if (r_auto)
            begin
                rf_auto <= 1'h1; // RL8
                pos_cmd <= main_sel; // RL9
                maint <= 1'h0; // RL5
            end
            if (r_aes_auto)
                aes_auto <= 1'h1; // RL10
            if (r_aes_main)
            begin
                aes_backup <= 1'h0; // RL12
                aes_auto <= 1'h0;
            end
            if (r_aes_backup)
            begin
                aes_backup <= 1'h1; // RL13
                aes_auto <= 1'h0;
            end
        end
    end

    // ==================================================
    // Coaxial switch transfer tracking
    wire sw_match;
    assign sw_match = lvl[`TRC_IN_LOOP_CLOSED] // RL16
        & (pos_cmd ? (lvl[`TRC_IN_IND_SECOND] & ~lvl[`TRC_IN_IND_FIRST])
                   : (lvl[`TRC_IN_IND_FIRST] & ~lvl[`TRC_IN_IND_SECOND]));

    // RF stays off from the command until the switch reports arrival
    always @(posedge clk_sys)
    begin
        if (rst)
            sw_state <= SW_MOVE;
        else if (ce)
        begin
            case (sw_state)
                SW_READY:
                    if (pos_cmd != switch_drive_second || !sw_match)
                        sw_state <= SW_MOVE; // RL18
                SW_MOVE:
                    if (pos_cmd == switch_drive_second && sw_match)
                        sw_state <= SW_READY; // RL18
                default:
                    sw_state <= SW_MOVE;
            endcase
        end
    end

    // ==================================================
    // Outputs
    wire ready, air_en, dummy_en;
    assign ready = (sw_state == SW_READY) && sw_match; // RL18
    // Interlock acts in local and remote mode alike
    assign air_en = ready & rf_enable_input;
    assign dummy_en = ready & maint & lvl[`TRC_IN_DUMMY_OK]; // RL14

    always @(posedge clk_sys)
    begin
        if (rst)
            {switch_drive_first, switch_drive_second, led_rf_enable_input,
                rf_enable_first_transmitter, rf_enable_second_transmitter,
                led_first_select, led_second_select, led_rf_auto,
                led_aes_auto, led_aes_main, led_aes_backup,
                led_maintenance, aes_source_backup} <= 13'h0000;
        else if (ce)
        begin
            switch_drive_first <= ~pos_cmd; // RL15
            switch_drive_second <= pos_cmd; // RL15
            rf_enable_first_transmitter <= pos_cmd ? dummy_en : air_en;
            rf_enable_second_transmitter <= pos_cmd ? air_en : dummy_en;
            led_rf_enable_input <= rf_enable_input;
            led_first_select <= ~main_sel;
            led_second_select <= main_sel;
            led_rf_auto <= rf_auto;
            led_aes_auto <= aes_auto;
            led_aes_main <= ~aes_backup;
            led_aes_backup <= aes_backup;
            led_maintenance <= maint;
            aes_source_backup <= aes_backup;
        end
    end

    // ==================================================
    // Register read port, data valid the cycle after the strobe
    always @(posedge clk_sys)
    begin
        if (rst)
            reg_rdata <= {`TRC_DATA_W{1'b0}};
        else if (ce)
        begin
            reg_rdata <= {`TRC_DATA_W{1'b0}};
            if (reg_rd)
            begin
                if (reg_addr == `TRC_REG_CFG)
                    reg_rdata <= {15'h0000, cfg_remote};
                else if (reg_addr == `TRC_REG_STAT)
                    reg_rdata <= {7'h00, cfg_remote, ready, pos_cmd, maint,
                                  aes_backup, aes_auto, rf_auto, main_sel,
                                  rf_enable_input};
                else if (reg_addr == `TRC_REG_INPUT)
                    reg_rdata <= {4'h0, lvl};
            end
        end
    end

endmodule // trc_top

// File: sim/trc_coax_model.sv
// Behavioural coaxial transfer switch with position contacts and interlock
module trc_coax_model (
    // Clock
    input logic clk_sys,
    // Position drives
    input logic switch_drive_first,
    input logic switch_drive_second,
    // Contacts, active low
    output logic switch_ind_first_n,
    output logic switch_ind_second_n,
    output logic switch_loop_closed_n
);
timeunit 1ns;
timeprecision 100ps;

// ==========================================
// Transit sequence
logic pos_second = 1'b0;
logic [4:0] move_cnt = 5'h0;
wire go = switch_drive_first | switch_drive_second;

always @(posedge clk_sys)
begin
    if (move_cnt != 5'h0)
        move_cnt <= move_cnt - 5'h1;
    else if (go && switch_drive_second != pos_second)
        move_cnt <= 5'h1e;
    // Contacts move well inside the open-loop span
    if (move_cnt == 5'h14)
        pos_second <= ~pos_second;
end

// Loop is open for the whole transit so RF is never switched hot
assign switch_loop_closed_n = (move_cnt != 5'h0);
// Contacts are released in transit; the pull-up reads them as open
assign switch_ind_first_n = (move_cnt != 5'h0) | pos_second;
assign switch_ind_second_n = (move_cnt != 5'h0) | ~pos_second;
endmodule // trc_coax_model

// File: sim/trc_top_sva.sv
// Assertion checker for the transfer remote control block
`include "trc_map.vh"

module trc_chk #(
    parameter [`TRC_CNT_W-1:0] DEBOUNCE_CYC = 4
)(
    // Clock and reset
    input wire clk_sys,
    input wire rst,
    // Register read
    input wire reg_rd,
    input wire [`TRC_DATA_W-1:0] reg_rdata,
    // Far-side contacts
    input wire dummy_load_interlock_n,
    input wire switch_ind_first_n,
    input wire switch_ind_second_n,
    input wire switch_loop_closed_n,
    // Outputs
    input wire switch_drive_first,
    input wire switch_drive_second,
    input wire rf_enable_first_transmitter,
    input wire rf_enable_second_transmitter,
    input wire led_rf_enable_input,
    input wire led_first_select,
    input wire led_second_select,
    input wire led_rf_auto,
    input wire led_aes_main,
    input wire led_aes_backup,
    input wire led_maintenance,
    input wire aes_source_backup
);
timeunit 1ns;
timeprecision 100ps;

// ==========================================
// Settling counters
// Margin covers sync stages, debounce and registered outputs
wire [`TRC_CNT_W:0] lim = DEBOUNCE_CYC + 10;
wire sw_bad = switch_loop_closed_n
    | (switch_drive_first & switch_ind_first_n)
    | (switch_drive_second & switch_ind_second_n);
wire dummy_rf = switch_drive_first ? rf_enable_second_transmitter
    : rf_enable_first_transmitter;
logic [`TRC_CNT_W:0] bad_cnt;
logic [`TRC_CNT_W:0] dl_cnt;

always @(posedge clk_sys)
begin
    if (rst || !sw_bad)
        bad_cnt <= '0;
    else if (bad_cnt <= lim)
        bad_cnt <= bad_cnt + 1'b1;
    if (rst || !dummy_load_interlock_n)
        dl_cnt <= '0;
    else if (dl_cnt <= lim)
        dl_cnt <= dl_cnt + 1'b1;
end

// ==========================================
// Assertions
default clocking cb @(posedge clk_sys); endclocking
default disable iff (rst);

drive_one_hot_a: assert property (
    !$past(rst) |-> switch_drive_first ^ switch_drive_second)
    else $error("position drives not one-hot");
select_one_hot_a: assert property (
    !$past(rst) |-> led_first_select ^ led_second_select)
    else $error("main select indicators not one-hot");
aes_one_hot_a: assert property (
    !$past(rst) |-> led_aes_main ^ led_aes_backup)
    else $error("audio source indicators not one-hot");
rf_quiet_a: assert property (
    (!led_rf_enable_input && !led_maintenance) [*4] |-> !rf_enable_first_transmitter
    && !rf_enable_second_transmitter)
    else $error("RF enabled while off and not in maintenance");
switch_unsafe_a: assert property (
    bad_cnt > lim |-> !rf_enable_first_transmitter
    && !rf_enable_second_transmitter)
    else $error("RF enabled while switch not settled");
dummy_intlk_a: assert property (
    dl_cnt > lim && $past(switch_drive_first, 3) == switch_drive_first
    |-> !dummy_rf)
    else $error("dummy load RF enabled with interlock open");
drive_follow_a: assert property (
    led_second_select [*3] |-> switch_drive_second)
    else $error("switch not driven to selected main");
aes_source_a: assert property (
    led_aes_backup [*3] |-> aes_source_backup)
    else $error("backup source not routed");
rdata_idle_a: assert property (
    !reg_rd |=> reg_rdata == 16'h0)
    else $error("read data not zero outside read");

cover property ($rose(led_maintenance));
cover property ($rose(led_rf_auto));
cover property ($rose(switch_drive_second));
endmodule // trc_chk

bind trc_top trc_chk #(.DEBOUNCE_CYC(DEBOUNCE_CYC)) u_chk (
    .clk_sys(clk_sys), .rst(rst), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .dummy_load_interlock_n(dummy_load_interlock_n),
    .switch_ind_first_n(switch_ind_first_n),
    .switch_ind_second_n(switch_ind_second_n),
    .switch_loop_closed_n(switch_loop_closed_n),
    .switch_drive_first(switch_drive_first),
    .switch_drive_second(switch_drive_second),
    .rf_enable_first_transmitter(rf_enable_first_transmitter),
    .rf_enable_second_transmitter(rf_enable_second_transmitter),
    .led_rf_enable_input(led_rf_enable_input), .led_first_select(led_first_select),
    .led_second_select(led_second_select), .led_rf_auto(led_rf_auto),
    .led_aes_main(led_aes_main), .led_aes_backup(led_aes_backup),
    .led_maintenance(led_maintenance), .aes_source_backup(aes_source_backup));

// File: sim/trc_top_tb.sv
// Self-checking testbench for the transfer remote control block
module trc_top_tb;
timeunit 1ns;
timeprecision 100ps;

// ==========================================
// Stimulus and observed outputs
logic clk_sys = 1'b0;
logic rst = 1'b1;
logic ce = 1'b1;
logic [3:0] reg_addr = 4'h0;
logic [15:0] reg_wdata = 16'h0;
logic reg_wr = 1'b0;
logic reg_rd = 1'b0;
logic [15:0] reg_rdata;
logic [7:0] pins_n = 8'hff;
logic dl_n = 1'b1;
logic ind1_n, ind2_n, loop_n, drv1, drv2, rf1, rf2;
logic [8:0] led;
wire [15:0] outs = {3'h0, drv1, drv2, rf1, rf2, led};
int miscompares = 0;
int comparisons = 0;

always #12.5 clk_sys = ~clk_sys;

trc_top #(.DEBOUNCE_CYC(18'h4)) uut (
    .clk_sys(clk_sys), .rst(rst), .ce(ce), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .rf_enable_input_n(pins_n[0]),
    .rf_disable_input_n(pins_n[1]), .first_xmtr_to_antenna_n(pins_n[2]),
    .second_xmtr_to_antenna_n(pins_n[3]),
    .auto_rf_transfer_input_n(pins_n[4]),
    .auto_aes_transfer_input_n(pins_n[5]),
    .main_aes_select_input_n(pins_n[6]),
    .backup_aes_select_input_n(pins_n[7]), .dummy_load_interlock_n(dl_n),
    .switch_ind_first_n(ind1_n), .switch_ind_second_n(ind2_n),
    .switch_loop_closed_n(loop_n), .switch_drive_first(drv1),
    .switch_drive_second(drv2), .rf_enable_first_transmitter(rf1),
    .rf_enable_second_transmitter(rf2), .led_rf_enable_input(led[8]),
    .led_first_select(led[7]), .led_second_select(led[6]),
    .led_rf_auto(led[5]), .led_aes_auto(led[4]), .led_aes_main(led[3]),
    .led_aes_backup(led[2]), .led_maintenance(led[1]),
    .aes_source_backup(led[0]));

trc_coax_model sw (
    .clk_sys(clk_sys), .switch_drive_first(drv1), .switch_drive_second(drv2),
    .switch_ind_first_n(ind1_n), .switch_ind_second_n(ind2_n),
    .switch_loop_closed_n(loop_n));

// ==========================================
// Access tasks
task automatic chk(input logic [15:0] got, input logic [15:0] exp);
begin
    comparisons++;
    if (got !== exp)
    begin
        miscompares++;
        $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
end
endtask

task automatic wr(input logic [3:0] a, input logic [15:0] d);
begin
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
end
endtask

task automatic rd(input logic [3:0] a, input logic [15:0] exp);
begin
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    @(negedge clk_sys);
    chk(reg_rdata, exp);
    @(posedge clk_sys);
end
endtask

// Momentary closure well past debounce, then release and settle
task automatic pulse(input logic [7:0] m);
begin
    pins_n <= ~m;
    repeat (16) @(posedge clk_sys);
    pins_n <= 8'hff;
    repeat (16) @(posedge clk_sys);
end
endtask

task automatic co(input logic [15:0] exp);
begin
    @(negedge clk_sys);
    chk(outs, exp);
    @(posedge clk_sys);
end
endtask

task final_report;
begin
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
        $display("All checks passed");
    else
        $display("Checks failed");
    $finish;
end
endtask

// ==========================================
// Tests
initial
begin
    repeat (12) @(posedge clk_sys);
    rst <= 1'b0;
    repeat (40) @(posedge clk_sys);
    co(16'h1088);
    rd(4'h4, 16'h0);
    rd(4'h8, 16'h0080);
    rd(4'h2, 16'h0);
    rd(4'h0, 16'h0);
    pulse(8'h01);
    co(16'h1088);
    $display("reset and local-only test done");
    wr(4'h4, 16'h0001);
    rd(4'h8, 16'h0180);
    pulse(8'h01);
    co(16'h1588);
    pulse(8'h03);
    co(16'h1088);
    pulse(8'h0c);
    co(16'h1088);
    pulse(8'h01);
    pulse(8'h08);
    repeat (60) @(posedge clk_sys);
    co(16'h0b48);
    $display("RF control test done");
    dl_n <= 1'b0;
    wr(4'h0, 16'h0100);
    repeat (20) @(posedge clk_sys);
    co(16'h0f4a);
    dl_n <= 1'b1;
    repeat (20) @(posedge clk_sys);
    co(16'h0b4a);
    dl_n <= 1'b0;
    pulse(8'h10);
    co(16'h0b68);
    pulse(8'h04);
    repeat (60) @(posedge clk_sys);
    co(16'h1588);
    wr(4'h0, 16'h0100);
    repeat (20) @(posedge clk_sys);
    co(16'h178a);
    pulse(8'h02);
    co(16'h1088);
    $display("maintenance test done");
    pulse(8'h80);
    co(16'h1085);
    pins_n <= 8'hdf;
    repeat (16) @(posedge clk_sys);
    co(16'h1095);
    wr(4'h0, 16'h0200);
    repeat (4) @(posedge clk_sys);
    co(16'h1095);
    pins_n <= 8'hff;
    repeat (16) @(posedge clk_sys);
    pulse(8'hc0);
    co(16'h1095);
    pulse(8'h40);
    co(16'h1088);
    $display("audio test done");
    // A strobe while the clock enable is low must be lost
    ce <= 1'b0;
    wr(4'h4, 16'h0000);
    ce <= 1'b1;
    rd(4'h4, 16'h0001);
    $display("clock enable test done");
    final_report;
end

initial
begin
    repeat (5000) @(posedge clk_sys);
    miscompares++;
    final_report;
end
endmodule // trc_top_tb
